// ===== common/status_pkg.sv
// package: widths, bit positions, reset values and access selectors for status reporting
package status_pkg;
  localparam int PART_W = 16;
  localparam int STB_W = 8;
  localparam int ESR_W = 8;
  localparam int SEL_W = 4;
  localparam int ERR_W = 16;
  localparam int ERR_DEPTH = 16;
  // reset values of the writable parts
  localparam logic [PART_W-1:0] RISING_RST = 16'h7FFF;
  localparam logic [PART_W-1:0] FALLING_RST = 16'h0000;
  localparam logic [PART_W-1:0] ENABLE_RST = 16'h0000;
  localparam logic [STB_W-1:0] SRE_RST = 8'h00;
  localparam logic [ESR_W-1:0] ESE_RST = 8'h00;
  // summary byte bit positions
  localparam int STB_ERRQ_BIT = 2;
  localparam int STB_QUESTIONABLE_SUM_BIT = 3;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_MSS_BIT = 6;
  localparam int STB_OPERATION_SUM_BIT = 7;
  localparam logic [STB_W-1:0] SRE_USED = 8'hBC;
  // command selectors
  localparam logic [SEL_W-1:0] SEL_STB = 4'h0;
  localparam logic [SEL_W-1:0] SEL_SRE = 4'h1;
  localparam logic [SEL_W-1:0] SEL_ESR = 4'h2;
  localparam logic [SEL_W-1:0] SEL_ESE = 4'h3;
  localparam logic [SEL_W-1:0] SEL_Q_COND = 4'h4;
  localparam logic [SEL_W-1:0] SEL_Q_RISE = 4'h5;
  localparam logic [SEL_W-1:0] SEL_Q_FALL = 4'h6;
  localparam logic [SEL_W-1:0] SEL_Q_EVT = 4'h7;
  localparam logic [SEL_W-1:0] SEL_Q_ENA = 4'h8;
  localparam logic [SEL_W-1:0] SEL_O_COND = 4'h9;
  localparam logic [SEL_W-1:0] SEL_O_RISE = 4'hA;
  localparam logic [SEL_W-1:0] SEL_O_FALL = 4'hB;
  localparam logic [SEL_W-1:0] SEL_O_EVT = 4'hC;
  localparam logic [SEL_W-1:0] SEL_O_ENA = 4'hD;
  localparam logic [SEL_W-1:0] SEL_ERRQ = 4'hE;
endpackage

// ===== rtl/scpi_status_reg.sv
// five-part status register with transition filters, sticky events and sum bit
`timescale 1ns/10ps
module scpi_status_reg
  import status_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [PART_W-2:0] cond_in,
  input wire logic wr_rise,
  input wire logic wr_fall,
  input wire logic wr_ena,
  input wire logic rd_evt,
  input wire logic [PART_W-1:0] wdata,
  output logic [PART_W-1:0] cond,
  output logic [PART_W-1:0] rise,
  output logic [PART_W-1:0] fall,
  output logic [PART_W-1:0] evt,
  output logic [PART_W-1:0] ena,
  output logic sum
);
  logic [PART_W-2:0] cond_q, rise_q, fall_q, evt_q, ena_q;

  // msb kept out of storage so it can never read one
  assign cond = {1'b0, cond_q};
  assign rise = {1'b0, rise_q};
  assign fall = {1'b0, fall_q};
  assign evt = {1'b0, evt_q};
  assign ena = {1'b0, ena_q};
  assign sum = |(evt_q & ena_q);

  genvar b;
  generate
    for (b = 0; b < PART_W - 1; b++) begin : g_bit
      always_ff @(posedge clk) begin
        if (srst) begin
          cond_q[b] <= 1'b0;
        end else begin
          cond_q[b] <= cond_in[b];
        end
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          rise_q[b] <= RISING_RST[b];
          fall_q[b] <= FALLING_RST[b];
          ena_q[b] <= ENABLE_RST[b];
        end else begin
          if (wr_rise) rise_q[b] <= wdata[b];
          if (wr_fall) fall_q[b] <= wdata[b];
          if (wr_ena) ena_q[b] <= wdata[b];
        end
      end

      // set wins over the read clear so no edge is lost
      always_ff @(posedge clk) begin
        if (srst) begin
          evt_q[b] <= 1'b0;
        end else if ((cond_in[b] & ~cond_q[b] & rise_q[b])
                     | (~cond_in[b] & cond_q[b] & fall_q[b])) begin
          evt_q[b] <= 1'b1;
        end else if (rd_evt) begin
          evt_q[b] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule // scpi_status_reg

// ===== rtl/error_queue.sv
// first-in first-out error and event queue
`timescale 1ns/10ps
module error_queue
  import status_pkg::*;
#(
  parameter int WIDTH = ERR_W,
  parameter int DEPTH = ERR_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic push,
  input wire logic [WIDTH-1:0] din,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic do_push, do_pop;

  // a push into a full queue is dropped; the oldest entries are kept
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign empty = (cnt_q == '0);
  assign full = (cnt_q == (AW+1)'(DEPTH));
  assign head = mem[rp_q];

  always_ff @(posedge clk) begin
    if (do_push) mem[wp_q] <= din;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      if (do_pop) rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule // error_queue

// ===== rtl/status_reporting_hierarchy.sv
// status byte, standard event register, service request and command access
`timescale 1ns/10ps
module status_reporting_hierarchy
  import status_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [PART_W-2:0] questionable_sum_status,
  input wire logic [PART_W-2:0] operation_sum_status,
  input wire logic [ESR_W-1:0] std_event_set,
  input wire logic output_message_available,
  input wire logic err_push,
  input wire logic [ERR_W-1:0] err_code,
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [SEL_W-1:0] acc_sel,
  input wire logic [PART_W-1:0] acc_wdata,
  input wire logic poll,
  output logic [PART_W-1:0] acc_rdata_q,
  output logic acc_rvalid_q,
  output logic [STB_W-1:0] poll_byte_q,
  output logic poll_valid_q,
  output logic [STB_W-1:0] summary_status_byte_q,
  output logic srq_q,
  output logic err_full_q
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [PART_W-2:0] questionable_sum_s1_q, questionable_sum_s2_q, questionable_sum_s3_q, questionable_sum_f_q;
  logic [PART_W-2:0] operation_sum_s1_q, operation_sum_s2_q, operation_sum_s3_q, operation_sum_f_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      questionable_sum_s1_q <= '0;
      questionable_sum_s2_q <= '0;
      questionable_sum_s3_q <= '0;
      operation_sum_s1_q <= '0;
      operation_sum_s2_q <= '0;
      operation_sum_s3_q <= '0;
    end else begin
      questionable_sum_s1_q <= questionable_sum_status;
      questionable_sum_s2_q <= questionable_sum_s1_q;
      questionable_sum_s3_q <= questionable_sum_s2_q;
      operation_sum_s1_q <= operation_sum_status;
      operation_sum_s2_q <= operation_sum_s1_q;
      operation_sum_s3_q <= operation_sum_s2_q;
    end
  end

  // a bit only moves once the last two stages agree, filtering glitches
  always_ff @(posedge clk) begin
    if (srst) begin
      questionable_sum_f_q <= '0;
      operation_sum_f_q <= '0;
    end else begin
      questionable_sum_f_q <= (questionable_sum_s2_q & questionable_sum_s3_q) | (questionable_sum_f_q & (questionable_sum_s2_q ^ questionable_sum_s3_q));
      operation_sum_f_q <= (operation_sum_s2_q & operation_sum_s3_q) | (operation_sum_f_q & (operation_sum_s2_q ^ operation_sum_s3_q));
    end
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  logic wr_sre, wr_ese, rd_esr;
  logic wr_q_rise, wr_q_fall, wr_q_ena, rd_q_evt;
  logic wr_o_rise, wr_o_fall, wr_o_ena, rd_o_evt;
  logic rd_errq;

  assign wr_sre = acc_wr & (acc_sel == SEL_SRE);
  assign wr_ese = acc_wr & (acc_sel == SEL_ESE);
  assign rd_esr = acc_rd & (acc_sel == SEL_ESR);
  assign wr_q_rise = acc_wr & (acc_sel == SEL_Q_RISE);
  assign wr_q_fall = acc_wr & (acc_sel == SEL_Q_FALL);
  assign wr_q_ena = acc_wr & (acc_sel == SEL_Q_ENA);
  assign rd_q_evt = acc_rd & (acc_sel == SEL_Q_EVT);
  assign wr_o_rise = acc_wr & (acc_sel == SEL_O_RISE);
  assign wr_o_fall = acc_wr & (acc_sel == SEL_O_FALL);
  assign wr_o_ena = acc_wr & (acc_sel == SEL_O_ENA);
  assign rd_o_evt = acc_rd & (acc_sel == SEL_O_EVT);
  assign rd_errq = acc_rd & (acc_sel == SEL_ERRQ);

  // ---------------------------------------------------------------
  // questionable and operation registers
  // ---------------------------------------------------------------
  logic [PART_W-1:0] q_cond, q_rise, q_fall, q_evt, q_ena;
  logic [PART_W-1:0] o_cond, o_rise, o_fall, o_evt, o_ena;
  logic questionable_sum, operation_sum;

  scpi_status_reg u_questionable_sum (
    .clk(clk),
    .srst(srst),
    .cond_in(questionable_sum_f_q),
    .wr_rise(wr_q_rise),
    .wr_fall(wr_q_fall),
    .wr_ena(wr_q_ena),
    .rd_evt(rd_q_evt),
    .wdata(acc_wdata),
    .cond(q_cond),
    .rise(q_rise),
    .fall(q_fall),
    .evt(q_evt),
    .ena(q_ena),
    .sum(questionable_sum)
  );

  scpi_status_reg u_operation_sum (
    .clk(clk),
    .srst(srst),
    .cond_in(operation_sum_f_q),
    .wr_rise(wr_o_rise),
    .wr_fall(wr_o_fall),
    .wr_ena(wr_o_ena),
    .rd_evt(rd_o_evt),
    .wdata(acc_wdata),
    .cond(o_cond),
    .rise(o_rise),
    .fall(o_fall),
    .evt(o_evt),
    .ena(o_ena),
    .sum(operation_sum)
  );

  // ---------------------------------------------------------------
  // error queue
  // ---------------------------------------------------------------
  logic [ERR_W-1:0] err_head;
  logic err_empty, err_full;

  error_queue #(
    .WIDTH(ERR_W),
    .DEPTH(ERR_DEPTH)
  ) u_errq (
    .clk(clk),
    .srst(srst),
    .push(err_push),
    .din(err_code),
    .pop(rd_errq),
    .head(err_head),
    .empty(err_empty),
    .full(err_full)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      err_full_q <= 1'b0;
    end else begin
      err_full_q <= err_full;
    end
  end

  // ---------------------------------------------------------------
  // standard event register and its enable
  // ---------------------------------------------------------------
  logic [ESR_W-1:0] esr_q, ese_q;
  logic standard_event_sum;

  // new events win over the clearing read
  always_ff @(posedge clk) begin
    if (srst) begin
      esr_q <= '0;
    end else if (rd_esr) begin
      esr_q <= std_event_set;
    end else begin
      esr_q <= esr_q | std_event_set;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ese_q <= ESE_RST;
    end else if (wr_ese) begin
      ese_q <= acc_wdata[ESR_W-1:0];
    end
  end

  // sticky bits make the level sum equal to the enabled rising edge
  assign standard_event_sum = |(esr_q & ese_q);

  // ---------------------------------------------------------------
  // summary byte and service request
  // ---------------------------------------------------------------
  logic [STB_W-1:0] sre_q, stb_cond, sre_eff, stb_new;
  logic master_request_summary;

  always_ff @(posedge clk) begin
    if (srst) begin
      sre_q <= SRE_RST;
    end else if (wr_sre) begin
      sre_q <= acc_wdata[STB_W-1:0] & SRE_USED;
    end
  end

  always_comb begin
    stb_cond = '0;
    stb_cond[STB_ERRQ_BIT] = ~err_empty;
    stb_cond[STB_QUESTIONABLE_SUM_BIT] = questionable_sum;
    stb_cond[STB_MAV_BIT] = output_message_available;
    stb_cond[STB_ESB_BIT] = standard_event_sum;
    stb_cond[STB_OPERATION_SUM_BIT] = operation_sum;
  end

  // bit 6 and the unused bits never take part in the request
  assign sre_eff = sre_q & SRE_USED;
  assign master_request_summary = |(stb_cond & sre_eff);
  assign stb_new = stb_cond & ~summary_status_byte_q & sre_eff;

  always_ff @(posedge clk) begin
    if (srst) begin
      summary_status_byte_q <= '0;
    end else begin
      summary_status_byte_q <= stb_cond;
      summary_status_byte_q[STB_MSS_BIT] <= master_request_summary;
    end
  end

  // a fresh request wins over a poll that clears the previous one
  always_ff @(posedge clk) begin
    if (srst) begin
      srq_q <= 1'b0;
    end else if (|stb_new) begin
      srq_q <= 1'b1;
    end else if (poll) begin
      srq_q <= 1'b0;
    end
  end

  // poll shows the request flag in bit 6, the query shows the summary
  always_ff @(posedge clk) begin
    if (srst) begin
      poll_byte_q <= '0;
      poll_valid_q <= 1'b0;
    end else begin
      poll_valid_q <= poll;
      if (poll) begin
        poll_byte_q <= summary_status_byte_q;
        poll_byte_q[STB_MSS_BIT] <= srq_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // command read-back
  // ---------------------------------------------------------------
  logic [PART_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (acc_sel)
      SEL_STB: rd_mux = {8'h00, summary_status_byte_q};
      SEL_SRE: rd_mux = {8'h00, sre_q};
      SEL_ESR: rd_mux = {8'h00, esr_q};
      SEL_ESE: rd_mux = {8'h00, ese_q};
      SEL_Q_COND: rd_mux = q_cond;
      SEL_Q_RISE: rd_mux = q_rise;
      SEL_Q_FALL: rd_mux = q_fall;
      SEL_Q_EVT: rd_mux = q_evt;
      SEL_Q_ENA: rd_mux = q_ena;
      SEL_O_COND: rd_mux = o_cond;
      SEL_O_RISE: rd_mux = o_rise;
      SEL_O_FALL: rd_mux = o_fall;
      SEL_O_EVT: rd_mux = o_evt;
      SEL_O_ENA: rd_mux = o_ena;
      SEL_ERRQ: rd_mux = err_empty ? '0 : err_head;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      acc_rdata_q <= '0;
      acc_rvalid_q <= 1'b0;
    end else begin
      acc_rvalid_q <= acc_rd;
      if (acc_rd) acc_rdata_q <= rd_mux;
    end
  end
endmodule // status_reporting_hierarchy

// ===== verif/status_checker.sv
// concurrent checks on the status reporting ports
`timescale 1ns/10ps
module status_checker
  import status_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic acc_rd,
  input wire logic poll,
  input wire logic output_message_available,
  input wire logic [PART_W-1:0] acc_rdata_q,
  input wire logic acc_rvalid_q,
  input wire logic [STB_W-1:0] poll_byte_q,
  input wire logic poll_valid_q,
  input wire logic [STB_W-1:0] summary_status_byte_q,
  input wire logic srq_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ---------------------------------------------------------------
  // assertions and cover points
  // ---------------------------------------------------------------
  a_unused_bits_zero: assert property (summary_status_byte_q[1:0] == 2'h0)
    else $error("unused summary bits set");
  a_master_bit_cause: assert property (summary_status_byte_q[6] |->
    (|{summary_status_byte_q[7], summary_status_byte_q[5:2]}))
    else $error("master bit without source");
  a_msg_bit_follows: assert property (!$past(srst) |->
    summary_status_byte_q[4] == $past(output_message_available))
    else $error("message bit wrong");
  a_srq_has_source: assert property ($rose(srq_q) |-> summary_status_byte_q[7:2] != 6'h00)
    else $error("request without summary bit");
  a_srq_drop_poll: assert property ($fell(srq_q) && !$past(srst) |-> $past(poll))
    else $error("request dropped without poll");
  a_poll_flag_bit: assert property (poll_valid_q |-> poll_byte_q[6] == $past(srq_q))
    else $error("poll flag wrong");
  a_poll_answer_next: assert property (poll |=> poll_valid_q && poll_byte_q[1:0] == 2'h0)
    else $error("poll answer missing");
  a_read_answer_next: assert property (acc_rd |=> acc_rvalid_q ##1 (!acc_rvalid_q || $past(acc_rd)))
    else $error("read answer wrong");
  a_read_top_zero: assert property (acc_rvalid_q |-> !acc_rdata_q[15] && $past(acc_rd))
    else $error("read data bit 15 set");
  c_srq_rise: cover property ($rose(srq_q));
  c_poll_seen: cover property (poll_valid_q && poll_byte_q[6]);
  c_master_set: cover property (summary_status_byte_q[6]);
endmodule // status_checker

// ===== verif/remote_ctl.sv
// remote controller model: register commands and serial poll
`timescale 1ns/10ps
module remote_ctl
  import status_pkg::*;
(
  input wire logic clk,
  output logic acc_wr,
  output logic acc_rd,
  output logic [SEL_W-1:0] acc_sel,
  output logic [PART_W-1:0] acc_wdata,
  output logic poll,
  input wire logic [PART_W-1:0] acc_rdata_q,
  input wire logic acc_rvalid_q,
  input wire logic [STB_W-1:0] poll_byte_q,
  input wire logic poll_valid_q
);
  initial begin
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    acc_sel = 4'h0;
    acc_wdata = 16'h0000;
    poll = 1'b0;
  end
  // ---------------------------------------------------------------
  // one request per call; released bus shows the inverse
  // ---------------------------------------------------------------
  task automatic req(input logic w, input logic [SEL_W-1:0] s, input logic [PART_W-1:0] v);
    @(posedge clk);
    #1;
    acc_wr = w;
    acc_rd = ~w;
    acc_sel = s;
    acc_wdata = v;
    @(posedge clk);
    #1;
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    acc_sel = ~s;
    acc_wdata = ~v;
  endtask
  task automatic read_reg(input logic [SEL_W-1:0] s, output logic [PART_W-1:0] d);
    req(1'b0, s, 16'h0000);
    d = (acc_rvalid_q === 1'b1) ? acc_rdata_q : 'x;
  endtask
  task automatic serial_poll(output logic [STB_W-1:0] b);
    @(posedge clk);
    #1;
    poll = 1'b1;
    @(posedge clk);
    #1;
    poll = 1'b0;
    b = (poll_valid_q === 1'b1) ? poll_byte_q : 'x;
  endtask
endmodule // remote_ctl

// ===== verif/tb.sv
// self-checking bench for the status reporting hierarchy
`timescale 1ns/10ps
module tb import status_pkg::*;;
  logic clk;
  logic srst = 1'b1;
  logic [PART_W-2:0] questionable_sum_status = 15'h0000;
  logic [PART_W-2:0] operation_sum_status = 15'h0000;
  logic [ESR_W-1:0] std_event_set = 8'h00;
  logic output_message_available = 1'b0;
  logic err_push = 1'b0;
  logic [ERR_W-1:0] err_code = 16'h0000;
  logic acc_wr, acc_rd, poll, acc_rvalid_q, poll_valid_q, srq_q, err_full_q;
  logic [SEL_W-1:0] acc_sel;
  logic [PART_W-1:0] acc_wdata, acc_rdata_q, d;
  logic [STB_W-1:0] poll_byte_q, summary_status_byte_q, pb;
  int fails = 0;
  int num_checks = 0;
  status_reporting_hierarchy dut (.clk, .srst, .questionable_sum_status, .operation_sum_status, .std_event_set,
    .output_message_available, .err_push, .err_code, .acc_wr, .acc_rd, .acc_sel, .acc_wdata, .poll,
    .acc_rdata_q, .acc_rvalid_q, .poll_byte_q, .poll_valid_q, .summary_status_byte_q, .srq_q, .err_full_q);
  remote_ctl ctl (.clk, .acc_wr, .acc_rd, .acc_sel, .acc_wdata, .poll, .acc_rdata_q, .acc_rvalid_q,
    .poll_byte_q, .poll_valid_q);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check_eq(input logic [PART_W-1:0] got, input logic [PART_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [SEL_W-1:0] s, input logic [PART_W-1:0] exp);
    ctl.read_reg(s, d);
    check_eq(d, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_status(input logic [SEL_W-1:0] b, input logic [PART_W-2:0] v);
    if (b == SEL_Q_COND) questionable_sum_status = v;
    else operation_sum_status = v;
    settle(8); // synchroniser and filter latency
  endtask
  // b selects the condition part; rise, fall, event, enable follow it
  task automatic chain(input logic [SEL_W-1:0] b, input int k);
    ctl.req(1'b1, b, 16'hFFFF);
    set_status(b, 15'h0003);
    rd(b, 16'h0003);
    rd(b + 4'h3, 16'h0003);
    rd(b + 4'h3, 16'h0000);
    ctl.req(1'b1, b + 4'h2, 16'hFFFF);
    rd(b + 4'h2, 16'h7FFF);
    ctl.req(1'b1, b + 4'h2, 16'h0002);
    ctl.req(1'b1, b + 4'h1, 16'h0000);
    set_status(b, 15'h0000);
    rd(b + 4'h3, 16'h0002);
    set_status(b, 15'h0001);
    rd(b + 4'h3, 16'h0000);
    ctl.req(1'b1, b + 4'h1, 16'h7FFF);
    ctl.req(1'b1, b + 4'h4, 16'h0010);
    rd(b + 4'h4, 16'h0010);
    ctl.req(1'b1, SEL_SRE, 16'h0001 << k);
    set_status(b, 15'h0011);
    check_eq({8'h00, summary_status_byte_q}, 16'h0040 | (16'h0001 << k));
    check_eq({15'h0000, srq_q}, 16'h0001);
    ctl.serial_poll(pb);
    check_eq({8'h00, pb}, 16'h0040 | (16'h0001 << k));
    check_eq({15'h0000, srq_q}, 16'h0000);
    rd(b + 4'h3, 16'h0010);
    settle(2);
    check_eq({8'h00, summary_status_byte_q}, 16'h0000);
    set_status(b, 15'h0000);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    #(50 * 5000);
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk);
    #1;
    srst = 1'b0;
    rd(SEL_Q_RISE, RISING_RST);
    rd(SEL_O_FALL, FALLING_RST);
    rd(SEL_Q_ENA, ENABLE_RST);
    rd(SEL_STB, 16'h0000);
    rd(4'hF, 16'h0000);
    ctl.req(1'b1, SEL_SRE, 16'h00FF);
    rd(SEL_SRE, 16'h00BC);
    chain(SEL_Q_COND, STB_QUESTIONABLE_SUM_BIT);
    chain(SEL_O_COND, STB_OPERATION_SUM_BIT);
    ctl.req(1'b1, SEL_SRE, 16'h0000);
    output_message_available = 1'b1;
    settle(2);
    check_eq({8'h00, summary_status_byte_q}, 16'h0010);
    check_eq({15'h0000, srq_q}, 16'h0000);
    output_message_available = 1'b0;
    ctl.req(1'b1, SEL_ESE, 16'h0001);
    ctl.req(1'b1, SEL_SRE, 16'h0020);
    std_event_set = 8'h01;
    settle(1);
    std_event_set = 8'h00;
    settle(3);
    check_eq({7'h00, srq_q, summary_status_byte_q}, 16'h0160);
    rd(SEL_ESR, 16'h0001);
    ctl.serial_poll(pb);
    check_eq({8'h00, pb}, 16'h0040);
    ctl.req(1'b1, SEL_SRE, 16'h0004);
    err_push = 1'b1;
    for (int i = 1; i < 4; i++) begin
      err_code = 16'h1111 * i[15:0];
      settle(1);
    end
    err_push = 1'b0;
    settle(3);
    check_eq({7'h00, srq_q, summary_status_byte_q}, 16'h0144);
    for (int i = 1; i < 5; i++) begin
      rd(SEL_ERRQ, (i < 4) ? 16'h1111 * i[15:0] : 16'h0000);
    end
    // fill past the depth; the extra push is dropped and the oldest kept
    err_push = 1'b1;
    for (int i = 0; i <= ERR_DEPTH; i++) begin
      err_code = 16'h0100 + i[15:0];
      settle(1);
    end
    err_push = 1'b0;
    settle(2);
    check_eq({15'h0000, err_full_q}, 16'h0001);
    for (int i = 0; i < ERR_DEPTH; i++) begin
      rd(SEL_ERRQ, 16'h0100 + i[15:0]);
    end
    rd(SEL_ERRQ, 16'h0000);
    check_eq({15'h0000, err_full_q}, 16'h0000);
    settle(2);
    check_eq({8'h00, summary_status_byte_q}, 16'h0000);
    report_and_stop();
  end
endmodule // tb
bind status_reporting_hierarchy status_checker u_chk (.clk, .srst, .acc_rd, .poll, .output_message_available,
  .acc_rdata_q, .acc_rvalid_q, .poll_byte_q, .poll_valid_q, .summary_status_byte_q, .srq_q);
